// ===== rtl/bbt_exec_unit.sv
// execution unit for relative branches, bit, shift, flag and X loads
//
// Summary of operation
// RL1: not-equal branch jumps to PC+k+1 when Z is clear; 1 or 2 cycles.
// RL2: carry-set and carry-clear branches follow C; 1 or 2 cycles.
// RL3: same-or-higher branches on C=0, lower branches on C=1.
// RL4: minus branches on N=1, plus on N=0; target PC+k+1.
// RL5: signed greater-or-equal branches when N xor V is zero.
// RL6: half-carry branches follow H set or clear.
// RL7: T-flag branches follow T set or clear.
// RL8: overflow branches follow V set or clear; 1 or 2 cycles.
// RL9: interrupt branches follow I; no branch alters any flag.
// RL10: I/O bit set and clear force one bit, two cycles, flags kept.
// RL11: logical left shift, bit 0 gets zero, updates Z C N V.
// RL12: logical right shift, bit 7 gets zero, updates Z C N V.
// RL13: rotate left through carry: old C to bit 0, bit 7 to C.
// RL14: arithmetic right shift keeps bit 7, updates Z C N V.
// RL15: bit store copies the chosen register bit into T only.
// RL16: bit load copies T into the chosen register bit, flags kept.
// RL17: set and clear of C N Z V H T I, one flag each, one cycle.
// RL18: set and clear of the signed test flag S alone.
// RL19: X post-increment load reads at X then X becomes X+1.
// RL20: X pre-decrement load makes X-1 first then reads there.
// RL21: signed less-than branches when N xor V is one.
// RL22: nibble swap exchanges register halves, no flag changes.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/10ps

module bbt_exec_unit
   import bbt_pkg::*;
#(
   parameter int PC_W = PC_W_DEF
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rstn,
   input  wire logic                 cmdValid,
   input  wire logic [4:0]           cmdOp,
   input  wire logic [DATA_W-1:0]    cmdRegData,
   input  wire logic [REG_IDX_W-1:0] cmdRegIdx,
   input  wire logic [BIT_IDX_W-1:0] cmdBit,
   input  wire logic [OFFS_W-1:0]    cmdOffset,
   input  wire logic [IO_ADDR_W-1:0] cmdIoAddr,
   input  wire logic [PTR_W-1:0]     cmdXPtr,
   input  wire logic [DATA_W-1:0]    ioRdData,
   input  wire logic [DATA_W-1:0]    memRdData,
   input  wire logic [RB_ADDR_W-1:0] regAddr,
   input  wire logic [DATA_W-1:0]    regWrData,
   input  wire logic                 regWr,
   input  wire logic                 regRd,
   output logic                      busyQ,
   output logic [PC_W-1:0]           pcQ,
   output logic [DATA_W-1:0]         flagsQ,
   output logic                      rfWrEnQ,
   output logic [REG_IDX_W-1:0]      rfWrIdxQ,
   output logic [DATA_W-1:0]         rfWrDataQ,
   output logic                      ioRdEnQ,
   output logic                      ioWrEnQ,
   output logic [IO_ADDR_W-1:0]      ioAddrQ,
   output logic [DATA_W-1:0]         ioWrDataQ,
   output logic                      memRdEnQ,
   output logic [PTR_W-1:0]          memAddrQ,
   output logic                      xWrEnQ,
   output logic [PTR_W-1:0]          xWrDataQ,
   output logic [DATA_W-1:0]         regRdDataQ
);

   bbt_state_t             stQ;
   bbt_state_t             stD;
   logic [BIT_IDX_W-1:0]   ioBitQ;
   logic                   ioSetQ;
   logic [DATA_W-1:0]      flagsD;
   logic [DATA_W-1:0]      resD;
   logic                   resWr;
   logic                   brTaken;
   logic                   isBranch;

   wire bbt_op_t           op = bbt_op_t'(cmdOp);
   wire                    accept = cmdValid && (stQ == ST_IDLE);
   wire                    fC = flagsQ[FLAG_C];
   wire                    fZ = flagsQ[FLAG_Z];
   wire                    fN = flagsQ[FLAG_N];
   wire                    fV = flagsQ[FLAG_V];
   wire                    fH = flagsQ[FLAG_H];
   wire                    fT = flagsQ[FLAG_T];
   wire                    fI = flagsQ[FLAG_I];
   wire                    signedLess = fN ^ fV;
   wire [PC_W-1:0]         offsetExt =
      PC_W'({{(PC_W-OFFS_W){cmdOffset[OFFS_W-1]}}, cmdOffset});
   wire [PC_W-1:0]         pcNext = pcQ + PC_W'(1);
   wire [PC_W-1:0]         brTarget = pcNext + offsetExt;
   wire [DATA_W-1:0]       bitMask = DATA_W'(1) << cmdBit;
   wire [DATA_W-1:0]       ioMask = DATA_W'(1) << ioBitQ;
   wire [PTR_W-1:0]        xInc = cmdXPtr + PTR_STEP;
   wire [PTR_W-1:0]        xDec = cmdXPtr - PTR_STEP;
   wire                    isIoOp = (op == OP_SET_IO_BIT) ||
                                    (op == OP_CLEAR_IO_BIT);
   wire                    isLoadOp = (op == OP_POINTER_LOAD_POSTINC) ||
                                      (op == OP_POINTER_LOAD_PREDEC);
   wire                    rbFlagsWr = regWr && (regAddr == RB_FLAGS);
   wire [DATA_W-1:0]       pcWide = DATA_W'(pcQ);
   wire [2*DATA_W-1:0]     pcPad = (2*DATA_W)'(pcQ);
   wire [DATA_W-1:0]       rbRdMux =
      (regAddr == RB_FLAGS) ? flagsQ :
      (regAddr == RB_PC_LO) ? pcWide :
      (regAddr == RB_PC_HI) ? pcPad[2*DATA_W-1:DATA_W] :
      (regAddr == RB_STATE) ? DATA_W'(stQ) : '0;

   // branch condition decode; no branch touches a flag
   always_comb begin
      isBranch = 1'b1;
      brTaken  = 1'b0;
      case (op)
         OP_BRANCH_NOT_EQUAL:     brTaken = !fZ;        // [RL1]
         OP_BRANCH_CARRY_SET:     brTaken = fC;         // [RL2]
         OP_BRANCH_CARRY_CLEAR:   brTaken = !fC;        // [RL2]
         OP_BRANCH_SAME_HIGHER:   brTaken = !fC;        // [RL3]
         OP_BRANCH_LOWER:         brTaken = fC;         // [RL3]
         OP_BRANCH_MINUS:         brTaken = fN;         // [RL4]
         OP_BRANCH_PLUS:          brTaken = !fN;        // [RL4]
         OP_BRANCH_GE_SIGNED:     brTaken = !signedLess; // [RL5]
         OP_BRANCH_LT_SIGNED:     brTaken = signedLess; // [RL21]
         OP_BRANCH_HALFCARRY_SET: brTaken = fH;         // [RL6]
         OP_BRANCH_HALFCARRY_CLR: brTaken = !fH;        // [RL6]
         OP_BRANCH_TFLAG_SET:     brTaken = fT;         // [RL7]
         OP_BRANCH_TFLAG_CLEAR:   brTaken = !fT;        // [RL7]
         OP_BRANCH_OVERFLOW_SET:  brTaken = fV;         // [RL8]
         OP_BRANCH_OVERFLOW_CLR:  brTaken = !fV;        // [RL8]
         OP_BRANCH_IRQ_ENABLED:   brTaken = fI;         // [RL9]
         OP_BRANCH_IRQ_DISABLED:  brTaken = !fI;        // [RL9]
         default:                 isBranch = 1'b0;
      endcase
   end

   // register results and flag updates of the one-cycle operations
   always_comb begin
      flagsD = rbFlagsWr ? regWrData : flagsQ;
      resD   = cmdRegData;
      resWr  = 1'b0;
      if (accept) begin
         case (op)
            OP_SHIFT_LEFT_LOGICAL, OP_ROTATE_LEFT_CARRY: begin
               resD = {cmdRegData[DATA_W-2:0],
                       (op == OP_ROTATE_LEFT_CARRY) && fC}; // [RL11] [RL13]
               flagsD[FLAG_C] = cmdRegData[DATA_W-1];         // [RL13]
               flagsD[FLAG_H] = cmdRegData[3];
               resWr = 1'b1;
            end
            OP_SHIFT_RIGHT_LOGICAL: begin
               resD = {1'b0, cmdRegData[DATA_W-1:1]};         // [RL12]
               flagsD[FLAG_C] = cmdRegData[0];
               resWr = 1'b1;
            end
            OP_ARITH_SHIFT_RIGHT: begin
               resD = {cmdRegData[DATA_W-1],
                       cmdRegData[DATA_W-1:1]};               // [RL14]
               flagsD[FLAG_C] = cmdRegData[0];
               resWr = 1'b1;
            end
            OP_SWAP_NIBBLES: begin
               resD = {cmdRegData[3:0], cmdRegData[7:4]};     // [RL22]
               resWr = 1'b1;
            end
            OP_STORE_BIT_TO_TFLAG:
               flagsD[FLAG_T] = cmdRegData[cmdBit];           // [RL15]
            OP_LOAD_BIT_FROM_TFLAG: begin
               resD = fT ? (cmdRegData | bitMask)
                         : (cmdRegData & ~bitMask);           // [RL16]
               resWr = 1'b1;
            end
            OP_FLAG_SET:   flagsD[cmdBit] = 1'b1;             // [RL17] [RL18]
            OP_FLAG_CLEAR: flagsD[cmdBit] = 1'b0;             // [RL17] [RL18]
            default: ;
         endcase
         // Z N V S follow the shifted value for all four shifts
         if (resWr && op != OP_SWAP_NIBBLES &&
             op != OP_LOAD_BIT_FROM_TFLAG) begin
            flagsD[FLAG_Z] = (resD == '0);                    // [RL11] [RL12]
            flagsD[FLAG_N] = resD[DATA_W-1];                  // [RL14]
            flagsD[FLAG_V] = resD[DATA_W-1] ^ flagsD[FLAG_C];
            flagsD[FLAG_S] = flagsD[FLAG_V] ^ resD[DATA_W-1];
         end
      end
   end

   // sequencing: only taken branches, I/O bit ops and loads take two cycles
   always_comb begin
      stD = ST_IDLE;
      case (stQ)
         ST_IDLE: begin
            if (accept && isBranch && brTaken)
               stD = ST_BRANCH;                               // [RL1]
            else if (accept && isIoOp)
               stD = ST_IOWR;                                 // [RL10]
            else if (accept && isLoadOp)
               stD = ST_LDWAIT;                               // [RL19]
         end
         ST_BRANCH, ST_IOWR, ST_LDWAIT: stD = ST_IDLE;
         default:                       stD = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         stQ    <= ST_IDLE;
         busyQ  <= 1'b0;
         flagsQ <= FLAGS_RST;
      end else begin
         stQ    <= stD;
         busyQ  <= (stD != ST_IDLE);
         // an instruction's flag update wins over a bus write
         flagsQ <= flagsD;
      end
   end

   // pc steps by one when not taken, by k+1 when taken
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         pcQ <= '0;
      else if (accept)
         pcQ <= (isBranch && brTaken) ? brTarget : pcNext;    // [RL4]
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rfWrEnQ   <= 1'b0;
         rfWrIdxQ  <= '0;
         rfWrDataQ <= '0;
      end else begin
         rfWrEnQ <= (resWr && accept) || (stQ == ST_LDWAIT);
         if (accept)
            rfWrIdxQ <= cmdRegIdx;
         if (stQ == ST_LDWAIT)
            rfWrDataQ <= memRdData;                           // [RL19]
         else if (accept && resWr)
            rfWrDataQ <= resD;
      end
   end

   // read-modify-write: the read answers in the same cycle as ioRdEnQ
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ioRdEnQ   <= 1'b0;
         ioWrEnQ   <= 1'b0;
         ioAddrQ   <= '0;
         ioWrDataQ <= '0;
         ioBitQ    <= '0;
         ioSetQ    <= 1'b0;
      end else begin
         ioRdEnQ <= accept && isIoOp;
         ioWrEnQ <= (stQ == ST_IOWR);
         if (accept && isIoOp) begin
            ioAddrQ <= cmdIoAddr;
            ioBitQ  <= cmdBit;
            ioSetQ  <= (op == OP_SET_IO_BIT);
         end
         if (stQ == ST_IOWR)
            ioWrDataQ <= ioSetQ ? (ioRdData | ioMask)
                                : (ioRdData & ~ioMask);       // [RL10]
      end
   end

   // the read address is the old X for post-increment, X-1 for pre-decrement
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         memRdEnQ <= 1'b0;
         memAddrQ <= '0;
         xWrEnQ   <= 1'b0;
         xWrDataQ <= '0;
      end else begin
         memRdEnQ <= accept && isLoadOp;
         xWrEnQ   <= accept && isLoadOp;
         if (accept && op == OP_POINTER_LOAD_POSTINC) begin
            memAddrQ <= cmdXPtr;                              // [RL19]
            xWrDataQ <= xInc;
         end else if (accept && op == OP_POINTER_LOAD_PREDEC) begin
            memAddrQ <= xDec;                                 // [RL20]
            xWrDataQ <= xDec;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         regRdDataQ <= '0;
      else if (regRd)
         regRdDataQ <= rbRdMux;
   end

   // ---------------- assertions ----------------
   property p_ne_taken;
      @(posedge ref_clk) disable iff (!rstn)
      accept && op == OP_BRANCH_NOT_EQUAL && !fZ
         |=> pcQ == $past(brTarget) && busyQ ##1 !busyQ;
   endproperty
   a_ne_taken: assert property (p_ne_taken) // [RL1]
      else $error("not-equal branch missed its target");

   property p_carry_not_taken;
      @(posedge ref_clk) disable iff (!rstn)
      accept && op == OP_BRANCH_CARRY_SET && !fC
         |=> pcQ == $past(pcNext) && !busyQ;
   endproperty
   a_carry_not_taken: assert property (p_carry_not_taken) // [RL2]
      else $error("carry branch taken with carry clear");

   property p_ge_flags;
      @(posedge ref_clk) disable iff (!rstn)
      accept && isBranch && !rbFlagsWr && op == OP_BRANCH_GE_SIGNED
         |=> pcQ == ($past(signedLess) ? $past(pcNext) : $past(brTarget))
             && $stable(flagsQ);
   endproperty
   a_ge_flags: assert property (p_ge_flags) // [RL5]
      else $error("signed branch wrong or flags changed");

   property p_io_set;
      @(posedge ref_clk) disable iff (!rstn)
      accept && op == OP_SET_IO_BIT
         |=> ioRdEnQ && busyQ ##1 ioWrEnQ && ioWrDataQ[ioBitQ]
             && ioAddrQ == $past(cmdIoAddr, 2);
   endproperty
   a_io_set: assert property (p_io_set) // [RL10]
      else $error("io bit set sequence wrong");

   property p_shift_left;
      @(posedge ref_clk) disable iff (!rstn)
      accept && op == OP_SHIFT_LEFT_LOGICAL
         |=> rfWrEnQ && rfWrDataQ == {$past(cmdRegData[6:0]), 1'b0}
             && flagsQ[FLAG_C] == $past(cmdRegData[7]);
   endproperty
   a_shift_left: assert property (p_shift_left) // [RL11]
      else $error("left shift result or carry wrong");

   property p_rotate;
      @(posedge ref_clk) disable iff (!rstn)
      accept && op == OP_ROTATE_LEFT_CARRY
         |=> rfWrDataQ[0] == $past(fC)
             && flagsQ[FLAG_C] == $past(cmdRegData[7]);
   endproperty
   a_rotate: assert property (p_rotate) // [RL13]
      else $error("rotate through carry wrong");

   property p_bit_store;
      @(posedge ref_clk) disable iff (!rstn)
      accept && !rbFlagsWr && op == OP_STORE_BIT_TO_TFLAG
         |=> flagsQ[FLAG_T] == $past(cmdRegData[cmdBit]) && !rfWrEnQ;
   endproperty
   a_bit_store: assert property (p_bit_store) // [RL15]
      else $error("bit store to T wrong");

   property p_load_inc;
      @(posedge ref_clk) disable iff (!rstn)
      accept && op == OP_POINTER_LOAD_POSTINC
         |=> memRdEnQ && memAddrQ == $past(cmdXPtr)
             && xWrDataQ == $past(cmdXPtr) + PTR_STEP ##1 rfWrEnQ;
   endproperty
   a_load_inc: assert property (p_load_inc) // [RL19]
      else $error("post-increment load wrong");

   property p_load_dec;
      @(posedge ref_clk) disable iff (!rstn)
      accept && op == OP_POINTER_LOAD_PREDEC
         |=> memAddrQ == $past(cmdXPtr) - PTR_STEP && xWrEnQ;
   endproperty
   a_load_dec: assert property (p_load_dec) // [RL20]
      else $error("pre-decrement load wrong");

   property p_swap;
      @(posedge ref_clk) disable iff (!rstn)
      accept && !rbFlagsWr && op == OP_SWAP_NIBBLES
         |=> rfWrDataQ == {$past(cmdRegData[3:0]), $past(cmdRegData[7:4])}
             && $stable(flagsQ);
   endproperty
   a_swap: assert property (p_swap) // [RL22]
      else $error("nibble swap wrong");

   property p_cov_taken;
      @(posedge ref_clk) disable iff (!rstn)
      accept && isBranch && brTaken;
   endproperty
   c_cov_taken: cover property (p_cov_taken);

   property p_cov_io;
      @(posedge ref_clk) disable iff (!rstn)
      accept && op == OP_CLEAR_IO_BIT ##2 accept;
   endproperty
   c_cov_io: cover property (p_cov_io);

   property p_cov_load;
      @(posedge ref_clk) disable iff (!rstn)
      accept && isLoadOp ##1 cmdValid && busyQ;
   endproperty
   c_cov_load: cover property (p_cov_load);

endmodule : bbt_exec_unit

// ===== rtl/bbt_pkg.sv
// constants and types shared by the branch, bit and shift execution unit
package bbt_pkg;

   localparam int PC_W_DEF    = 12;
   localparam int OFFS_W      = 7;
   localparam int DATA_W      = 8;
   localparam int PTR_W       = 16;
   localparam int IO_ADDR_W   = 6;
   localparam int REG_IDX_W   = 5;
   localparam int BIT_IDX_W   = 3;
   localparam int RB_ADDR_W   = 4;

   // status_flags_register bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
   localparam logic [PTR_W-1:0]  PTR_STEP  = 16'h0001;

   // register bus byte offsets
   localparam logic [RB_ADDR_W-1:0] RB_FLAGS = 4'h0;
   localparam logic [RB_ADDR_W-1:0] RB_PC_LO = 4'h4;
   localparam logic [RB_ADDR_W-1:0] RB_PC_HI = 4'h8;
   localparam logic [RB_ADDR_W-1:0] RB_STATE = 4'hc;

   typedef enum logic [4:0] {
      OP_NONE                 = 5'h00,
      OP_BRANCH_NOT_EQUAL     = 5'h01,
      OP_BRANCH_CARRY_SET     = 5'h02,
      OP_BRANCH_CARRY_CLEAR   = 5'h03,
      OP_BRANCH_SAME_HIGHER   = 5'h04,
      OP_BRANCH_LOWER         = 5'h05,
      OP_BRANCH_MINUS         = 5'h06,
      OP_BRANCH_PLUS          = 5'h07,
      OP_BRANCH_GE_SIGNED     = 5'h08,
      OP_BRANCH_LT_SIGNED     = 5'h09,
      OP_BRANCH_HALFCARRY_SET = 5'h0a,
      OP_BRANCH_HALFCARRY_CLR = 5'h0b,
      OP_BRANCH_TFLAG_SET     = 5'h0c,
      OP_BRANCH_TFLAG_CLEAR   = 5'h0d,
      OP_BRANCH_OVERFLOW_SET  = 5'h0e,
      OP_BRANCH_OVERFLOW_CLR  = 5'h0f,
      OP_BRANCH_IRQ_ENABLED   = 5'h10,
      OP_BRANCH_IRQ_DISABLED  = 5'h11,
      OP_SET_IO_BIT           = 5'h12,
      OP_CLEAR_IO_BIT         = 5'h13,
      OP_SHIFT_LEFT_LOGICAL   = 5'h14,
      OP_SHIFT_RIGHT_LOGICAL  = 5'h15,
      OP_ROTATE_LEFT_CARRY    = 5'h16,
      OP_ARITH_SHIFT_RIGHT    = 5'h17,
      OP_SWAP_NIBBLES         = 5'h18,
      OP_STORE_BIT_TO_TFLAG   = 5'h19,
      OP_LOAD_BIT_FROM_TFLAG  = 5'h1a,
      OP_FLAG_SET             = 5'h1b,
      OP_FLAG_CLEAR           = 5'h1c,
      OP_POINTER_LOAD_POSTINC = 5'h1d,
      OP_POINTER_LOAD_PREDEC  = 5'h1e
   } bbt_op_t;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_BRANCH = 4'b0010,
      ST_IOWR   = 4'b0100,
      ST_LDWAIT = 4'b1000
   } bbt_state_t;

endpackage : bbt_pkg

// ===== testbench/tb_bbt_exec_unit.sv
// self-checking bench for the branch, bit and shift execution unit
`timescale 1ns/10ps

module tb_bbt_exec_unit
   import bbt_pkg::*;
();
   localparam int PCW = PC_W_DEF;

   logic                 ref_clk    = 1'b0;
   logic                 rstn       = 1'b0;
   logic                 cmdValid   = 1'b0;
   logic [4:0]           cmdOp      = 5'h00;
   logic [DATA_W-1:0]    cmdRegData = 8'h00;
   logic [REG_IDX_W-1:0] cmdRegIdx  = 5'h00;
   logic [BIT_IDX_W-1:0] cmdBit     = 3'h0;
   logic [OFFS_W-1:0]    cmdOffset  = 7'h00;
   logic [IO_ADDR_W-1:0] cmdIoAddr  = 6'h00;
   logic [PTR_W-1:0]     cmdXPtr    = 16'h0000;
   logic [DATA_W-1:0]    ioRdData   = 8'h00;
   logic [DATA_W-1:0]    memRdData  = 8'h00;
   logic [RB_ADDR_W-1:0] regAddr    = 4'h0;
   logic [DATA_W-1:0]    regWrData  = 8'h00;
   logic                 regWr      = 1'b0;
   logic                 regRd      = 1'b0;
   logic                 busyQ;
   logic [PCW-1:0]       pcQ;
   logic [DATA_W-1:0]    flagsQ;
   logic                 rfWrEnQ;
   logic [REG_IDX_W-1:0] rfWrIdxQ;
   logic [DATA_W-1:0]    rfWrDataQ;
   logic                 ioRdEnQ;
   logic                 ioWrEnQ;
   logic [IO_ADDR_W-1:0] ioAddrQ;
   logic [DATA_W-1:0]    ioWrDataQ;
   logic                 memRdEnQ;
   logic [PTR_W-1:0]     memAddrQ;
   logic                 xWrEnQ;
   logic [PTR_W-1:0]     xWrDataQ;
   logic [DATA_W-1:0]    regRdDataQ;
   logic [PCW-1:0]       pcExp;
   int                   n_fail     = 0;
   int                   cmp_count  = 0;
   int                   cycles     = 0;

   bbt_exec_unit #(.PC_W(PCW)) dut (
      .ref_clk, .rstn, .cmdValid, .cmdOp, .cmdRegData, .cmdRegIdx,
      .cmdBit, .cmdOffset, .cmdIoAddr, .cmdXPtr, .ioRdData, .memRdData,
      .regAddr, .regWrData, .regWr, .regRd, .busyQ, .pcQ, .flagsQ,
      .rfWrEnQ, .rfWrIdxQ, .rfWrDataQ, .ioRdEnQ, .ioWrEnQ, .ioAddrQ,
      .ioWrDataQ, .memRdEnQ, .memAddrQ, .xWrEnQ, .xWrDataQ, .regRdDataQ
   );

   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude

   // the whole run needs well under a thousand cycles; this only catches a hang
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_fail++;
         conclude();
      end
   end

   task automatic chk(input string what, input logic [15:0] seen,
                      input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic busWr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regAddr   <= a;
      regWrData <= d;
      regWr     <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask : busWr

   task automatic busRd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 d = regRdDataQ;
   endtask : busRd

   // one command, taken at the second edge; returns with c1 outputs settled
   task automatic cmd(input logic [4:0] op, input logic [7:0] d,
                      input logic [2:0] b, input logic [6:0] k);
      @(posedge ref_clk);
      cmdValid   <= 1'b1;
      cmdOp      <= op;
      cmdRegData <= d;
      cmdBit     <= b;
      cmdOffset  <= k;
      cmdIoAddr  <= k[5:0];
      cmdRegIdx  <= d[4:0] ^ 5'h15;
      @(posedge ref_clk);
      cmdValid <= 1'b0;
      #1;
   endtask : cmd

   function automatic logic taken(input logic [4:0] op, input logic [7:0] f);
      case (op)
         OP_BRANCH_NOT_EQUAL:     return !f[FLAG_Z];
         OP_BRANCH_CARRY_SET:     return f[FLAG_C];
         OP_BRANCH_CARRY_CLEAR:   return !f[FLAG_C];
         OP_BRANCH_SAME_HIGHER:   return !f[FLAG_C];
         OP_BRANCH_LOWER:         return f[FLAG_C];
         OP_BRANCH_MINUS:         return f[FLAG_N];
         OP_BRANCH_PLUS:          return !f[FLAG_N];
         OP_BRANCH_GE_SIGNED:     return !(f[FLAG_N] ^ f[FLAG_V]);
         OP_BRANCH_LT_SIGNED:     return f[FLAG_N] ^ f[FLAG_V];
         OP_BRANCH_HALFCARRY_SET: return f[FLAG_H];
         OP_BRANCH_HALFCARRY_CLR: return !f[FLAG_H];
         OP_BRANCH_TFLAG_SET:     return f[FLAG_T];
         OP_BRANCH_TFLAG_CLEAR:   return !f[FLAG_T];
         OP_BRANCH_OVERFLOW_SET:  return f[FLAG_V];
         OP_BRANCH_OVERFLOW_CLR:  return !f[FLAG_V];
         OP_BRANCH_IRQ_ENABLED:   return f[FLAG_I];
         default:                 return !f[FLAG_I];
      endcase
   endfunction : taken

   // pc is untouched here, so it must still read zero
   task automatic testRegs();
      logic [7:0] v;
      busRd(RB_FLAGS, v);
      chk("flags reset", v, FLAGS_RST);
      busWr(RB_PC_LO, 8'h5c);
      busRd(RB_PC_LO, v);
      chk("pc low read-only", v, 8'h00);
      busRd(RB_STATE, v);
      chk("state idle", v, 8'h01);
      busWr(RB_FLAGS, 8'ha5);
      busRd(RB_FLAGS, v);
      chk("flags readback", v, 8'ha5);
      busRd(4'h2, v);
      chk("unmapped read", v, 8'h00);
      $display("test regs done");
   endtask : testRegs

   task automatic testBranch();
      logic [7:0] fl [4] = '{8'h00, 8'hff, 8'h04, 8'h69};
      logic [6:0] k;
      logic [7:0] v;
      logic       tk;
      pcExp = '0;
      for (int op = 1; op <= 17; op++) begin
         for (int j = 0; j < 4; j++) begin
            k = 7'(op * 29 + j * 53);
            busWr(RB_FLAGS, fl[j]);
            tk = taken(5'(op), fl[j]);
            cmd(5'(op), 8'h00, 3'h0, k);
            pcExp = tk ? pcExp + {{(PCW - OFFS_W){k[6]}}, k} + 1'b1
                       : pcExp + 1'b1;
            chk("pc", pcQ, pcExp);
            chk("busy", busyQ, tk);
            chk("flags", flagsQ, fl[j]);
            if (tk) begin
               @(posedge ref_clk);
               #1 chk("busy end", busyQ, 1'b0);
            end
         end
      end
      busRd(RB_PC_LO, v);
      chk("pc low", v, pcExp[7:0]);
      busRd(RB_PC_HI, v);
      chk("pc high", v, 8'(pcExp[PCW-1:8]));
      $display("test branch done");
   endtask : testBranch

   task automatic testIo();
      logic [2:0] b;
      logic [7:0] e;
      for (int i = 0; i < 4; i++) begin
         b = 3'(i * 3 + 1);
         busWr(RB_FLAGS, 8'h3c);
         ioRdData <= i[0] ? 8'hff : 8'h00;
         cmd(i[0] ? OP_CLEAR_IO_BIT : OP_SET_IO_BIT, 8'h00, b, 7'(i + 33));
         chk("ioRdEn", ioRdEnQ, 1'b1);
         chk("ioAddr", ioAddrQ, cmdIoAddr);
         chk("busy", busyQ, 1'b1);
         @(posedge ref_clk);
         #1;
         e = i[0] ? ~(8'h01 << b) : (8'h01 << b);
         chk("ioWrEn", ioWrEnQ, 1'b1);
         chk("ioWrData", ioWrDataQ, e);
         chk("flags", flagsQ, 8'h3c);
         chk("busy end", busyQ, 1'b0);
      end
      $display("test io done");
   endtask : testIo

   task automatic testShift();
      logic [7:0] dv [3] = '{8'h80, 8'h01, 8'h96};
      logic [7:0] d, r, fe;
      logic       c;
      for (int op = OP_SHIFT_LEFT_LOGICAL; op <= OP_SWAP_NIBBLES; op++) begin
         for (int i = 0; i < 6; i++) begin
            d = dv[i % 3];
            fe = (i < 3) ? 8'h00 : 8'hff;
            busWr(RB_FLAGS, fe);
            cmd(5'(op), d, 3'h0, 7'h00);
            case (op)
               OP_SHIFT_LEFT_LOGICAL:  {c, r} = {d, 1'b0};
               OP_SHIFT_RIGHT_LOGICAL: {r, c} = {1'b0, d};
               OP_ROTATE_LEFT_CARRY:   {c, r} = {d, fe[FLAG_C]};
               OP_ARITH_SHIFT_RIGHT:   {r, c} = {d[7], d};
               default:                {c, r} = {fe[FLAG_C], d[3:0], d[7:4]};
            endcase
            // swap leaves every flag alone
            if (op != OP_SWAP_NIBBLES) begin
               fe[FLAG_C] = c;
               fe[FLAG_Z] = (r == 8'h00);
               fe[FLAG_N] = r[7];
               fe[FLAG_V] = r[7] ^ c;
               fe[FLAG_S] = c;
            end
            if (op == OP_SHIFT_LEFT_LOGICAL || op == OP_ROTATE_LEFT_CARRY)
               fe[FLAG_H] = d[3];
            chk("rfWrEn", rfWrEnQ, 1'b1);
            chk("rfWrIdx", rfWrIdxQ, cmdRegIdx);
            chk("rfWrData", rfWrDataQ, r);
            chk("flags", flagsQ, fe);
         end
      end
      $display("test shift done");
   endtask : testShift

   task automatic testBits();
      logic [7:0] fe, r;
      for (int i = 0; i < 16; i++) begin
         fe = i[3] ? 8'hff : 8'h00;
         busWr(RB_FLAGS, fe);
         cmd(OP_STORE_BIT_TO_TFLAG, 8'h55, 3'(i), 7'h00);
         fe[FLAG_T] = ~i[0];
         chk("flags", flagsQ, fe);
         // target bit always differs from T, so a missed write shows
         cmd(OP_LOAD_BIT_FROM_TFLAG, 8'haa, 3'(i), 7'h00);
         r = 8'haa;
         r[i[2:0]] = fe[FLAG_T];
         chk("rfWrData", rfWrDataQ, r);
         chk("flags", flagsQ, fe);
      end
      for (int i = 0; i < 16; i++) begin
         fe = i[3] ? 8'hff : 8'h00;
         busWr(RB_FLAGS, fe);
         cmd(i[3] ? OP_FLAG_CLEAR : OP_FLAG_SET, 8'h00, 3'(i), 7'h00);
         fe[i[2:0]] = ~i[3];
         chk("flags", flagsQ, fe);
      end
      $display("test bits done");
   endtask : testBits

   task automatic testLoad();
      logic [15:0] xv [2] = '{16'h10fe, 16'h0000};
      logic [15:0] a;
      for (int i = 0; i < 2; i++) begin
         @(posedge ref_clk);
         cmdXPtr   <= xv[i];
         memRdData <= 8'hc3 ^ 8'(i);
         cmd(i[0] ? OP_POINTER_LOAD_PREDEC : OP_POINTER_LOAD_POSTINC,
             8'h07, 3'h0, 7'h00);
         a = i[0] ? xv[i] - PTR_STEP : xv[i];
         chk("memRdEn", memRdEnQ, 1'b1);
         chk("memAddr", memAddrQ, a);
         chk("xWrEn", xWrEnQ, 1'b1);
         chk("xWrData", xWrDataQ, i[0] ? a : a + PTR_STEP);
         chk("busy", busyQ, 1'b1);
         @(posedge ref_clk);
         #1;
         chk("rfWrEn", rfWrEnQ, 1'b1);
         chk("rfWrData", rfWrDataQ, 8'hc3 ^ 8'(i));
      end
      $display("test load done");
   endtask : testLoad

   initial begin
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      testRegs();
      testBranch();
      testIo();
      testShift();
      testBits();
      testLoad();
      conclude();
   end

endmodule : tb_bbt_exec_unit
